// ### rtl/isr_pkg.sv
// Constants and types of the instrument status-reporting block.
// Assumes one clock; commands arrive already parsed as op codes.
package isr_pkg;
  // ----------------------------------------
  // Mask test event bit positions
  // ----------------------------------------
  localparam int TEV_W = 6;
  localparam int TEV_TEST_DONE = 0;
  localparam int TEV_TEST_FAIL = 1;
  localparam int TEV_LOW_AMP = 2;
  localparam int TEV_HIGH_AMP = 3;
  localparam int TEV_ALIGN_DONE = 4;
  localparam int TEV_ALIGN_FAIL = 5;
  // ----------------------------------------
  // Operation status and status byte
  // ----------------------------------------
  localparam int OP_W = 16;
  localparam int OP_ACQ_BIT = 0;
  localparam int OP_ARM_BIT = 5;
  localparam int OP_MASK_BIT = 9;
  localparam int OP_AUTO_BIT = 11;
  localparam int OP_OVLD_BIT = 12;
  localparam int STB_W = 8;
  localparam int STB_ADV_BIT = 0;
  localparam int STB_OUT_AVAIL_BIT = 4;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OPSUM_BIT = 7;
  // ----------------------------------------
  // Error queue
  // ----------------------------------------
  localparam int ERR_DEPTH = 30;
  localparam int ERR_CODES = 29;
  localparam int ERR_W = 16;
  localparam int ERR_IW = 5;
  localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  // ----------------------------------------
  // Reset values and command codes
  // ----------------------------------------
  localparam logic [5:0] TEV_EN_RST = 6'h00;
  localparam logic [15:0] OP_EN_RST = 16'h0000;
  localparam logic [7:0] SRE_RST = 8'h00;
  typedef enum logic [3:0] {
    CMD_TEV_READ = 4'h0, CMD_TEV_EN_WR = 4'h1, CMD_TEV_EN_RD = 4'h2,
    CMD_OP_READ = 4'h3, CMD_OP_EN_WR = 4'h4, CMD_OP_EN_RD = 4'h5,
    CMD_ARM_READ = 4'h6, CMD_ACQ_READ = 4'h7, CMD_SRE_WR = 4'h8,
    CMD_STB_READ = 4'h9, CMD_ERR_READ = 4'hA, CMD_CLS = 4'hB,
    CMD_DSP_WR = 4'hC, CMD_ADV_WR = 4'hD, CMD_MSG_READ = 4'hE,
    CMD_NOP = 4'hF
  } isr_cmd_t;
endpackage : isr_pkg

// ### rtl/isr_status.sv
// Status-reporting core: event flags, enables, summaries, error queue.
// Assumes parsed commands and event pulses synchronous to clk.
`timescale 1ns/1ps
module isr_status #(
  parameter int OQ_W = 8,
  parameter int MSG_W = 16
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rstn, // Sync reset, active low
  input wire logic [5:0] maskEvt, // Mask condition pulses
  input wire logic armedEvt, // Trigger armed pulse
  input wire logic acqDoneEvt, // Acquisition done pulse
  input wire logic autoTrigEvt, // Auto trigger pulse
  input wire logic overloadEvt, // Overload pulse
  input wire logic cmdValid, // Command strobe
  input wire logic [3:0] cmdOp, // Command code
  input wire logic [15:0] cmdData, // Command argument
  input wire logic msgTerm, // Program message terminator seen
  input wire logic errPush, // Error detected
  input wire logic [15:0] errCode, // Error code
  input wire logic outPush, // Byte into output queue
  input wire logic outPop, // Byte out of output queue
  output logic rspValid, // Query answer strobe
  output logic [15:0] rspData, // Query answer
  output logic srq // Service request
);
  // ----------------------------------------
  // Flag and enable registers
  // ----------------------------------------
  logic [5:0] tevReg, tevNext, tevEnReg, tevEnNext;
  logic armReg, armNext, acqReg, acqNext;
  logic autoReg, autoNext, ovldReg, ovldNext;
  logic [15:0] opEnReg, opEnNext;
  logic [7:0] sreReg, sreNext;
  logic advReg, advNext, termReg, termNext;
  logic [MSG_W-1:0] msgReg, msgNext;
  logic [OQ_W-1:0] oqReg, oqNext;
  logic [15:0] opVec;
  logic [7:0] stb;
  logic clsNow;

  function automatic logic isCmd(input logic v, input logic [3:0] op,
                                 input isr_pkg::isr_cmd_t c);
    isCmd = v && (op == c);
  endfunction : isCmd

  function automatic logic [4:0] wrapAdd(input logic [4:0] a, input logic [4:0] b);
    logic [5:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 6'(isr_pkg::ERR_DEPTH)) s = s - 6'(isr_pkg::ERR_DEPTH);
    wrapAdd = s[4:0];
  endfunction : wrapAdd

  assign clsNow = isCmd(cmdValid, cmdOp, isr_pkg::CMD_CLS);

  always_comb begin
    opVec = 16'h0000;
    opVec[isr_pkg::OP_ACQ_BIT] = acqReg;
    opVec[isr_pkg::OP_ARM_BIT] = armReg;
    opVec[isr_pkg::OP_MASK_BIT] = |(tevReg & tevEnReg);
    opVec[isr_pkg::OP_AUTO_BIT] = autoReg;
    opVec[isr_pkg::OP_OVLD_BIT] = ovldReg;
    stb = 8'h00;
    stb[isr_pkg::STB_ADV_BIT] = advReg;
    stb[isr_pkg::STB_OUT_AVAIL_BIT] = (oqReg != '0);
    stb[isr_pkg::STB_OPSUM_BIT] = |(opVec & opEnReg);
    stb[isr_pkg::STB_RQS_BIT] = |(stb & sreReg);
  end
  assign srq = stb[isr_pkg::STB_RQS_BIT];

  always_comb begin
    // Sets win over clears in the same cycle
    tevNext = tevReg;
    if (isCmd(cmdValid, cmdOp, isr_pkg::CMD_TEV_READ) || clsNow) tevNext = 6'h00;
    tevNext = tevNext | maskEvt;
    armNext = (armReg && !(isCmd(cmdValid, cmdOp, isr_pkg::CMD_ARM_READ) || clsNow))
              || armedEvt;
    acqNext = (acqReg && !(isCmd(cmdValid, cmdOp, isr_pkg::CMD_ACQ_READ) || clsNow))
              || acqDoneEvt;
    autoNext = (autoReg && !(isCmd(cmdValid, cmdOp, isr_pkg::CMD_OP_READ) || clsNow))
               || autoTrigEvt;
    ovldNext = (ovldReg && !(isCmd(cmdValid, cmdOp, isr_pkg::CMD_OP_READ) || clsNow))
               || overloadEvt;
    tevEnNext = tevEnReg;
    if (isCmd(cmdValid, cmdOp, isr_pkg::CMD_TEV_EN_WR)) tevEnNext = cmdData[5:0];
    opEnNext = opEnReg;
    if (isCmd(cmdValid, cmdOp, isr_pkg::CMD_OP_EN_WR)) opEnNext = cmdData;
    sreNext = sreReg;
    if (isCmd(cmdValid, cmdOp, isr_pkg::CMD_SRE_WR)) sreNext = cmdData[7:0];
    sreNext[isr_pkg::STB_RQS_BIT] = 1'b0;
    msgNext = msgReg;
    advNext = advReg;
    if (clsNow) begin
      msgNext = '0;
      advNext = 1'b0;
    end
    if (isCmd(cmdValid, cmdOp, isr_pkg::CMD_DSP_WR)) msgNext = cmdData[MSG_W-1:0];
    if (isCmd(cmdValid, cmdOp, isr_pkg::CMD_ADV_WR)) begin
      msgNext = cmdData[MSG_W-1:0];
      advNext = 1'b1;
    end
    termNext = msgTerm ? 1'b1 : (cmdValid ? 1'b0 : termReg);
    oqNext = oqReg;
    if (outPop && oqReg != '0) oqNext = oqNext - 1'b1;
    if (outPush && oqNext != '1) oqNext = oqNext + 1'b1;
    if (clsNow && termReg) oqNext = '0;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tevReg <= 6'h00;
      armReg <= 1'b0;
      acqReg <= 1'b0;
      autoReg <= 1'b0;
      ovldReg <= 1'b0;
      tevEnReg <= isr_pkg::TEV_EN_RST;
      opEnReg <= isr_pkg::OP_EN_RST;
      sreReg <= isr_pkg::SRE_RST;
      msgReg <= '0;
      advReg <= 1'b0;
      termReg <= 1'b0;
      oqReg <= '0;
    end else begin
      tevReg <= tevNext;
      armReg <= armNext;
      acqReg <= acqNext;
      autoReg <= autoNext;
      ovldReg <= ovldNext;
      tevEnReg <= tevEnNext;
      opEnReg <= opEnNext;
      sreReg <= sreNext;
      msgReg <= msgNext;
      advReg <= advNext;
      termReg <= termNext;
      oqReg <= oqNext;
    end
  end

  // ----------------------------------------
  // Error queue
  // ----------------------------------------
  logic [15:0] errMem [isr_pkg::ERR_DEPTH];
  logic [15:0] errMemNext [isr_pkg::ERR_DEPTH];
  logic [4:0] errHead, errHeadNext, errCnt, errCntNext, errTail;
  logic errMark, errMarkNext;
  logic [15:0] errRdVal;
  logic errRd;

  assign errRd = isCmd(cmdValid, cmdOp, isr_pkg::CMD_ERR_READ);

  always_comb begin
    errMemNext = errMem;
    errHeadNext = errHead;
    errCntNext = errCnt;
    errMarkNext = errMark;
    errRdVal = isr_pkg::ERR_NONE;
    errTail = 5'h00;
    if (errRd && errCnt != 5'h00) begin
      errRdVal = errMem[errHead];
      errHeadNext = wrapAdd(errHead, 5'h01);
      errCntNext = errCnt - 5'h01;
      if (errCntNext == 5'h00) begin
        errHeadNext = 5'h00;
        errMarkNext = 1'b0;
      end
    end
    if (errPush && !errMarkNext) begin
      errTail = wrapAdd(errHeadNext, errCntNext);
      if (errCntNext < 5'(isr_pkg::ERR_CODES)) begin
        errMemNext[errTail] = errCode;
        errCntNext = errCntNext + 5'h01;
      end else begin
        errMemNext[errTail] = isr_pkg::ERR_OVERFLOW;
        errCntNext = 5'(isr_pkg::ERR_DEPTH);
        errMarkNext = 1'b1;
      end
    end
    if (clsNow) begin
      errHeadNext = 5'h00;
      errCntNext = 5'h00;
      errMarkNext = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      errHead <= 5'h00;
      errCnt <= 5'h00;
      errMark <= 1'b0;
    end else begin
      errHead <= errHeadNext;
      errCnt <= errCntNext;
      errMark <= errMarkNext;
    end
    errMem <= errMemNext;
  end

  // ----------------------------------------
  // Query answers
  // ----------------------------------------
  logic rspValidNext;
  logic [15:0] rspDataNext;

  always_comb begin
    rspValidNext = cmdValid;
    rspDataNext = 16'h0000;
    unique case (cmdOp)
      isr_pkg::CMD_TEV_READ: rspDataNext = {10'h000, tevReg};
      isr_pkg::CMD_TEV_EN_RD: rspDataNext = {10'h000, tevEnReg};
      isr_pkg::CMD_OP_READ: rspDataNext = opVec;
      isr_pkg::CMD_OP_EN_RD: rspDataNext = opEnReg;
      isr_pkg::CMD_ARM_READ: rspDataNext = {15'h0000, armReg};
      isr_pkg::CMD_ACQ_READ: rspDataNext = {15'h0000, acqReg};
      isr_pkg::CMD_STB_READ: rspDataNext = {8'h00, stb};
      isr_pkg::CMD_ERR_READ: rspDataNext = errRdVal;
      isr_pkg::CMD_MSG_READ: rspDataNext = 16'(msgReg);
      default: rspValidNext = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rspValid <= 1'b0;
      rspData <= 16'h0000;
    end else begin
      rspValid <= rspValidNext;
      rspData <= rspDataNext;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_TEV_SET: assert property (maskEvt != 6'h00 |=> (tevReg & $past(maskEvt)) == $past(maskEvt))
    else $error("Mask event flag not set");
  AST_AMP_ALIGN: assert property ($rose(maskEvt[isr_pkg::TEV_HIGH_AMP])
    ##0 maskEvt[isr_pkg::TEV_ALIGN_FAIL]
    |=> tevReg[isr_pkg::TEV_HIGH_AMP] && tevReg[isr_pkg::TEV_ALIGN_FAIL])
    else $error("Amplitude or align flag not set");
  AST_TEV_READ: assert property (isCmd(cmdValid, cmdOp, isr_pkg::CMD_TEV_READ)
    && maskEvt == 6'h00 |=> tevReg == 6'h00 && rspValid && rspData[5:0] == $past(tevReg))
    else $error("Mask event read wrong");
  AST_MASK_OFF: assert property (tevEnReg == 6'h00 |-> !opVec[isr_pkg::OP_MASK_BIT])
    else $error("Disabled mask flag reached summary");
  AST_OP_OFF: assert property (opEnReg == 16'h0000 |-> !stb[isr_pkg::STB_OPSUM_BIT])
    else $error("Disabled operation bit reached summary");
  AST_ARMED: assert property (armedEvt && opEnReg[isr_pkg::OP_ARM_BIT]
    && !isCmd(cmdValid, cmdOp, isr_pkg::CMD_OP_EN_WR)
    |=> opVec[isr_pkg::OP_ARM_BIT] && stb[isr_pkg::STB_OPSUM_BIT])
    else $error("Armed event not summarised");
  AST_ARM_HOLD: assert property (armReg && !cmdValid |=> armReg)
    else $error("Armed flag lost");
  AST_ACQ_HOLD: assert property (acqDoneEvt |=> acqReg ##1 (acqReg || $past(cmdValid)))
    else $error("Acquisition flag lost");
  AST_ERR_CAP: assert property (errCnt <= 5'(isr_pkg::ERR_DEPTH))
    else $error("Error queue above capacity");
  AST_ERR_OVF: assert property (errPush && errCnt == 5'(isr_pkg::ERR_CODES) && !errMark
    && !cmdValid |=> errCnt == 5'(isr_pkg::ERR_DEPTH) && errMark
    && errMem[wrapAdd(errHead, 5'(isr_pkg::ERR_CODES))] == isr_pkg::ERR_OVERFLOW)
    else $error("Overflow entry not written");
  AST_ERR_EMPTY: assert property (errRd && errCnt == 5'h00 |=> rspValid && rspData == 16'h0000)
    else $error("Empty error query not zero");
  AST_CLS: assert property (clsNow |=> errCnt == 5'h00 && tevReg == $past(maskEvt))
    else $error("Clear status incomplete");
  AST_OUT_AVAIL: assert property (outPush && !clsNow |=> stb[isr_pkg::STB_OUT_AVAIL_BIT])
    else $error("Output available bit missing");
  AST_SRQ: assert property (stb[isr_pkg::STB_OPSUM_BIT]
    && sreReg[isr_pkg::STB_OPSUM_BIT] |-> srq)
    else $error("Service request missing");
  AST_DSP: assert property (isCmd(cmdValid, cmdOp, isr_pkg::CMD_DSP_WR) && !advReg |=> !advReg)
    else $error("Display write set notice bit");

  COV_OVF: cover property (errMark);
  COV_SRQ: cover property ($rose(srq));
  COV_CLS_TERM: cover property (clsNow && termReg && oqReg != '0);
  COV_SET_CLR: cover property (isCmd(cmdValid, cmdOp, isr_pkg::CMD_ARM_READ) && armedEvt);
endmodule : isr_status

// ### tb/isr_host_model.sv
// Controlling computer model: issues parsed commands, reads answers.
// Assumes the status block takes commands on the rising clk edge.
`timescale 1ns/1ps
module isr_host_model (
  input wire logic clk, // Instrument clock
  output logic cmdValid, // Command strobe
  output logic [3:0] cmdOp, // Command code
  output logic [15:0] cmdData, // Command argument
  output logic msgTerm, // Program message terminator
  output logic outPop, // Byte taken from output queue
  input wire logic rspValid, // Query answer strobe
  input wire logic [15:0] rspData // Query answer
);
  initial begin
    cmdValid = 1'b0;
    cmdOp = isr_pkg::CMD_NOP;
    cmdData = 16'h0000;
    msgTerm = 1'b0;
    outPop = 1'b0;
  end
  // Entered and left 1 ns after a rising edge; one idle cycle follows
  task automatic issue(input logic [3:0] op, input logic [15:0] d, output logic v,
                       output logic [15:0] r);
    cmdOp = op;
    cmdData = d;
    cmdValid = 1'b1;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmdOp = isr_pkg::CMD_NOP;
    cmdData = ~d;
    v = rspValid;
    r = rspData;
    @(posedge clk);
    #1;
  endtask : issue
  task automatic strobe(input logic term, input logic pop);
    msgTerm = term;
    outPop = pop;
    @(posedge clk);
    #1;
    msgTerm = 1'b0;
    outPop = 1'b0;
    @(posedge clk);
    #1;
  endtask : strobe
endmodule : isr_host_model

// ### tb/tb_instrument_status_reporting.sv
// Self-checking bench of the status-reporting block.
// Assumes the host model drives the command side.
`timescale 1ns/1ps
module tb_instrument_status_reporting;
  logic clk, rstn, armedEvt, acqDoneEvt, autoTrigEvt, overloadEvt;
  logic errPush, outPush, cmdValid, msgTerm, outPop, rspValid, srq, v;
  logic [5:0] maskEvt;
  logic [3:0] cmdOp;
  logic [15:0] cmdData, errCode, rspData, r;
  int bad_count = 0;
  int check_count = 0;
  isr_status DUT (.clk(clk), .rstn(rstn), .maskEvt(maskEvt), .armedEvt(armedEvt),
    .acqDoneEvt(acqDoneEvt), .autoTrigEvt(autoTrigEvt), .overloadEvt(overloadEvt),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData), .msgTerm(msgTerm),
    .errPush(errPush), .errCode(errCode), .outPush(outPush), .outPop(outPop),
    .rspValid(rspValid), .rspData(rspData), .srq(srq));
  isr_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData),
    .msgTerm(msgTerm), .outPop(outPop), .rspValid(rspValid), .rspData(rspData));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic q(input logic [3:0] op, input logic [15:0] exp, input logic [15:0] m);
    host.issue(op, 16'h0000, v, r);
    chk({15'h0000, v}, 16'h0001);
    chk(r & m, exp);
  endtask : q
  task automatic w(input logic [3:0] op, input logic [15:0] d);
    host.issue(op, d, v, r);
  endtask : w
  // Flags: armed, acq done, auto trig, overload, error, output byte
  task automatic pulse(input logic [5:0] m, input logic [5:0] f, input logic [15:0] c);
    maskEvt = m;
    {armedEvt, acqDoneEvt, autoTrigEvt, overloadEvt, errPush, outPush} = f;
    errCode = c;
    @(posedge clk);
    #1;
    maskEvt = 6'h00;
    {armedEvt, acqDoneEvt, autoTrigEvt, overloadEvt, errPush, outPush} = 6'h00;
    errCode = ~c;
    @(posedge clk);
    #1;
  endtask : pulse
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    maskEvt = 6'h00;
    {armedEvt, acqDoneEvt, autoTrigEvt, overloadEvt, errPush, outPush} = 6'h00;
    errCode = 16'h0000;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({15'h0000, srq}, 16'h0000);
    q(isr_pkg::CMD_TEV_EN_RD, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 6'h00, 16'h0000);
      q(isr_pkg::CMD_TEV_READ, 16'h0001 << i, 16'hFFFF);
      q(isr_pkg::CMD_TEV_READ, 16'h0000, 16'hFFFF);
    end
    pulse(6'h28, 6'h00, 16'h0000);
    q(isr_pkg::CMD_TEV_READ, 16'h0028, 16'hFFFF);
    w(isr_pkg::CMD_TEV_EN_WR, 16'h002A);
    q(isr_pkg::CMD_TEV_EN_RD, 16'h002A, 16'hFFFF);
    pulse(6'h01, 6'h00, 16'h0000);
    q(isr_pkg::CMD_OP_READ, 16'h0000, 16'h0200);
    pulse(6'h02, 6'h00, 16'h0000);
    q(isr_pkg::CMD_OP_READ, 16'h0200, 16'h0200);
    q(isr_pkg::CMD_TEV_READ, 16'h0003, 16'hFFFF);
    q(isr_pkg::CMD_OP_READ, 16'h0000, 16'h0200);
    w(isr_pkg::CMD_OP_EN_WR, 16'h0021);
    w(isr_pkg::CMD_SRE_WR, 16'h0080);
    pulse(6'h00, 6'h20, 16'h0000);
    chk({15'h0000, srq}, 16'h0001);
    q(isr_pkg::CMD_STB_READ, 16'h00C0, 16'h00C0);
    q(isr_pkg::CMD_OP_READ, 16'h0020, 16'h0021);
    q(isr_pkg::CMD_ARM_READ, 16'h0001, 16'h0001);
    chk({15'h0000, srq}, 16'h0000);
    pulse(6'h00, 6'h20, 16'h0000);
    q(isr_pkg::CMD_ARM_READ, 16'h0001, 16'h0001);
    w(isr_pkg::CMD_OP_EN_WR, 16'h0020);
    pulse(6'h00, 6'h10, 16'h0000);
    chk({15'h0000, srq}, 16'h0000);
    q(isr_pkg::CMD_OP_READ, 16'h0001, 16'h0021);
    w(isr_pkg::CMD_OP_EN_WR, 16'h0001);
    q(isr_pkg::CMD_OP_EN_RD, 16'h0001, 16'hFFFF);
    chk({15'h0000, srq}, 16'h0001);
    w(isr_pkg::CMD_CLS, 16'h0000);
    q(isr_pkg::CMD_ACQ_READ, 16'h0000, 16'h0001);
    pulse(6'h00, 6'h0C, 16'h0000);
    q(isr_pkg::CMD_OP_READ, 16'h1800, 16'h1800);
    q(isr_pkg::CMD_OP_READ, 16'h0000, 16'h1800);
    for (int i = 1; i <= 31; i++) begin
      pulse(6'h00, 6'h02, i[15:0]);
    end
    for (int i = 1; i <= 29; i++) begin
      q(isr_pkg::CMD_ERR_READ, i[15:0], 16'hFFFF);
    end
    q(isr_pkg::CMD_ERR_READ, 16'hFEA2, 16'hFFFF);
    q(isr_pkg::CMD_ERR_READ, 16'h0000, 16'hFFFF);
    pulse(6'h00, 6'h02, 16'h0007);
    q(isr_pkg::CMD_ERR_READ, 16'h0007, 16'hFFFF);
    pulse(6'h00, 6'h02, 16'h0003);
    w(isr_pkg::CMD_CLS, 16'h0000);
    q(isr_pkg::CMD_ERR_READ, 16'h0000, 16'hFFFF);
    w(isr_pkg::CMD_SRE_WR, 16'h0000);
    pulse(6'h00, 6'h01, 16'h0000);
    q(isr_pkg::CMD_STB_READ, 16'h0010, 16'h0010);
    host.strobe(1'b0, 1'b1);
    q(isr_pkg::CMD_STB_READ, 16'h0000, 16'h0010);
    pulse(6'h00, 6'h01, 16'h0000);
    host.strobe(1'b1, 1'b0);
    w(isr_pkg::CMD_CLS, 16'h0000);
    q(isr_pkg::CMD_STB_READ, 16'h0000, 16'h0010);
    pulse(6'h00, 6'h01, 16'h0000);
    w(isr_pkg::CMD_CLS, 16'h0000);
    q(isr_pkg::CMD_STB_READ, 16'h0010, 16'h0010);
    w(isr_pkg::CMD_DSP_WR, 16'h1234);
    q(isr_pkg::CMD_STB_READ, 16'h0000, 16'h0001);
    w(isr_pkg::CMD_ADV_WR, 16'h55AA);
    q(isr_pkg::CMD_STB_READ, 16'h0001, 16'h0001);
    q(isr_pkg::CMD_MSG_READ, 16'h55AA, 16'hFFFF);
    w(isr_pkg::CMD_CLS, 16'h0000);
    q(isr_pkg::CMD_MSG_READ, 16'h0000, 16'hFFFF);
    report_and_stop();
  end
endmodule : tb_instrument_status_reporting
